// [rtl/pcr_pkg.sv]
// Constants, tables and types for the command register map block
package pcr_pkg;
  // Number of writable command registers held in the map
  localparam int NREG = 22;
  localparam int IW = 5;
  // Register indices into the tables below
  localparam int I_OP = 0;
  localparam int I_ONOFF = 1;
  localparam int I_VSET = 2;
  localparam int I_TRIM = 3;
  localparam int I_VMAX = 4;
  localparam int I_MH = 5;
  localparam int I_ML = 6;
  localparam int I_RATE = 7;
  localparam int I_DROOP = 8;
  localparam int I_FREQ = 9;
  localparam int I_PHASE = 10;
  localparam int I_GAIN = 11;
  localparam int I_CSOFF = 12;
  localparam int I_OVF = 13;
  localparam int I_OVR = 14;
  localparam int I_OVW = 15;
  localparam int I_UVW = 16;
  localparam int I_UVF = 17;
  localparam int I_UVR = 18;
  localparam int I_OC = 19;
  localparam int I_UC = 20;
  localparam int I_OT = 21;
  // Command codes, in index order
  localparam logic [7:0] CODE_TAB [NREG] = '{
    8'h01, 8'h02, 8'h21, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h33, 8'h37,
    8'h38, 8'h39, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h4b, 8'h4f};
  // Reset values; strap-derived entries are reloaded just after reset
  localparam logic [15:0] RST_TAB [NREG] = '{
    16'h0000, 16'h0017, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'hba00, 16'h0000, 16'h0000, 16'h0000, 16'hb2ae, 16'h0000, 16'h0000,
    16'h0080, 16'h0000, 16'h0000, 16'h0000, 16'h0080, 16'he280, 16'he57f,
    16'hebe8};
  // Strap scale factor in twentieths of the strapped voltage, 0 = none
  localparam logic [7:0] SCALE_TAB [NREG] = '{
    8'h00, 8'h00, 8'h14, 8'h00, 8'h16, 8'h15, 8'h13, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h17, 8'h00, 8'h16, 8'h12, 8'h11, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [31:0] SCALE_DEN = 32'h0000_0014;
  // Byte-wide commands and strap-loaded commands
  localparam logic [NREG-1:0] BYTE_MASK = 22'h04_4003;
  localparam logic [NREG-1:0] STRAP_MASK = 22'h03_a674;
  // Data-less commands and the fixed format descriptor
  localparam logic [7:0] C_CLEAR = 8'h03;
  localparam logic [7:0] C_STORE = 8'h15;
  localparam logic [7:0] C_RESTORE = 8'h16;
  localparam logic [7:0] C_FMT = 8'h20;
  localparam logic [7:0] FMT_VAL = 8'h13;
  // Run mode and on/off source bits
  localparam int OP_ON = 7;
  localparam logic [1:0] MRG_LO = 2'h1;
  localparam logic [1:0] MRG_HI = 2'h2;
  localparam int CFG_USE = 4;
  localparam int CFG_CMD = 3;
  localparam int CFG_PIN = 2;
  localparam int CFG_POL = 1;
  localparam int CFG_IMM = 0;
  // Fault action field: bit 7 or bit 6 set shuts the output down
  localparam int RSP_HI = 7;
  localparam int RSP_LO = 6;
  // Sticky flag positions
  localparam int NFLAG = 7;
  localparam int F_OVF = 0;
  localparam int F_OVW = 1;
  localparam int F_UVW = 2;
  localparam int F_UVF = 3;
  localparam int F_OC = 4;
  localparam int F_UC = 5;
  localparam int F_OT = 6;
  // Ramp tick period
  localparam int CLK_NS = 40;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  // Transfer kinds on the command port
  typedef enum logic [2:0] {K_SEND, K_WBYTE, K_WWORD, K_RBYTE, K_RWORD} pcr_kind_t;
endpackage

// [rtl/pcr_nv_if.sv]
// Port bundle between the register map and its settings store
`timescale 1ns/10ps
interface pcr_nv_if #(parameter int AW = 5, parameter int DW = 16);
  logic we;
  logic re;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport host (output we, output re, output addr, output wdata, input rdata);
  modport mem (input we, input re, input addr, input wdata, output rdata);
endinterface

// [rtl/pcr_nvmem.sv]
// Settings store for saved user configuration, registered read port
`timescale 1ns/10ps
module pcr_nvmem #(
  parameter int DEPTH = 22,
  parameter int AW = 5,
  parameter int DW = 16
) (
  input wire logic sys_clk_i,
  pcr_nv_if.mem nv
);
  logic [DW-1:0] mem_r [DEPTH];
  logic [DW-1:0] rdata_r;

  initial
  begin
    if (DEPTH > (1 << AW))
      $error("pcr_nvmem: depth exceeds address range");
  end

  // Contents survive reset on purpose, like the nonvolatile array
  always_ff @(posedge sys_clk_i)
  begin
    if (nv.we)
      mem_r[nv.addr] <= nv.wdata;
    if (nv.re)
      rdata_r <= mem_r[nv.addr];
  end

  assign nv.rdata = rdata_r;
endmodule

// [rtl/pcr_regmap.sv]
// Command register map of the step-down module: settings, ramp, limits
// Operation
// - Byte 01h selects on, off and margin high/low modes.
// - Byte 02h picks pin and command on/off sources, default 17h.
// - Send-byte 15h copies all settings into the saved store.
// - Send-byte 16h reloads the working settings from the store.
// - Code 20h reads back fixed 13h, linear format exponent -13.
// - Word 21h holds nominal output voltage, default from strap.
// - Signed word 23h, default zero, offsets the commanded voltage.
// - Word 24h caps commanded voltage, default 1.1 times strap.
// - Words 25h/26h give margin levels, 1.05 and 0.95 times strap.
// - Voltage changes ramp at rate word 27h, default 1 V/ms.
// - Word 28h holds load-line slope, default zero.
// - Word 33h sets switching frequency, default from strap.
// - Word 37h sets phase offset against shared sync clock.
// - Words 38h/39h give current-sense gain and offset.
// - Overvoltage fault when output exceeds word 40h.
// - Byte 41h decides the overvoltage fault action, default shutdown.
// - Overvoltage warning when output exceeds word 42h.
// - Undervoltage warning when output falls below word 43h.
// - Undervoltage fault below word 44h, action from byte 45h.
// - Overcurrent fault when current exceeds word 46h.
// - Undercurrent fault when current falls below word 4Bh.
// - Over-temperature fault when temperature exceeds word 4Fh.
`timescale 1ns/10ps
module pcr_regmap
  import pcr_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_kind_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [15:0] cmd_data_i,
  input wire logic en_pin_i,
  input wire logic [15:0] vout_strap_i,
  input wire logic [15:0] freq_strap_i,
  input wire logic [6:0] addr_strap_i,
  input wire logic [15:0] vout_meas_i,
  input wire logic [15:0] iout_meas_i,
  input wire logic [15:0] temp_meas_i,
  output logic rsp_valid_o,
  output logic rsp_err_o,
  output logic [15:0] rsp_data_o,
  output logic busy_o,
  output logic out_enable_o,
  output logic [15:0] vout_ref_o,
  output logic [15:0] freq_o,
  output logic [15:0] phase_o,
  output logic [15:0] droop_o,
  output logic [15:0] cs_gain_o,
  output logic [15:0] cs_offset_o,
  output logic [NFLAG-1:0] flags_o
);
  typedef enum logic [1:0] {S_INIT, S_IDLE, S_STORE, S_RESTORE} pcr_state_t;

  initial
  begin
    if (TICK_CYCLES < 1)
      $error("pcr_regmap: tick period must be at least one cycle");
    if (NREG > (1 << IW) - 1)
      $error("pcr_regmap: register count exceeds index width");
  end

  // Strap fraction in twentieths
  function automatic logic [15:0] scale(input logic [15:0] v, input logic [7:0] n);
    logic [31:0] p;
    p = 32'(v) * 32'(n) / SCALE_DEN;
    return p[15:0];
  endfunction

  // Mantissa/exponent word to fixed point with 16 fraction bits
  function automatic logic signed [47:0] l11(input logic [15:0] w);
    logic signed [47:0] m;
    int e;
    m = 48'(signed'(w[10:0]));
    e = int'(signed'(w[15:11]));
    return m <<< (e + 16);
  endfunction

  // Rate word to setpoint LSBs per microsecond, 1 V/ms gives 8
  function automatic logic [15:0] rate_step(input logic [15:0] w);
    logic [31:0] m;
    int sh;
    m = 32'(w[10:0]);
    sh = int'(signed'(w[15:11])) + 3;
    m = (sh >= 0) ? (m << sh) : (m >> (-sh));
    if (m == 32'h0)
      m = 32'h1;
    if (m > 32'h0000_ffff)
      m = 32'h0000_ffff;
    return m[15:0];
  endfunction

  pcr_state_t st_r, st_nxt;
  logic [15:0] regs_r [NREG];
  logic [15:0] reg_nxt [NREG];
  logic [NREG-1:0] hit;
  logic [IW-1:0] idx_r, idx_nxt;
  logic [IW-1:0] ld_idx_r;
  logic rvld_r;
  logic nv_valid_r;
  logic [NFLAG-1:0] flags_r, flags_nxt, cond;
  logic shut_r, shut_nxt;
  logic en_r, en_nxt;
  logic [15:0] vnow_r, vnow_nxt;
  logic [15:0] tick_r;
  logic rsp_valid_r, rsp_err_r, busy_r;
  logic [15:0] rsp_data_r;
  pcr_nv_if #(.AW(IW), .DW(16)) nv ();

  pcr_nvmem #(.DEPTH(NREG), .AW(IW), .DW(16)) u_nvmem (
    .sys_clk_i(sys_clk_i),
    .nv(nv.mem)
  );

  // Command decode
  wire acc = cmd_valid_i && (st_r == S_IDLE);
  wire any_hit = |hit;
  wire is_byte = |(hit & BYTE_MASK);
  wire is_send = cmd_kind_i == K_SEND;
  wire wr_ok = acc && any_hit && ((cmd_kind_i == K_WBYTE && is_byte) ||
                                  (cmd_kind_i == K_WWORD && !is_byte));
  wire rd_reg = any_hit && ((cmd_kind_i == K_RBYTE && is_byte) ||
                            (cmd_kind_i == K_RWORD && !is_byte));
  wire rd_fmt = (cmd_code_i == C_FMT) && (cmd_kind_i == K_RBYTE);
  wire rd_ok = acc && (rd_reg || rd_fmt);
  wire clr_ok = acc && is_send && (cmd_code_i == C_CLEAR);
  wire sto_ok = acc && is_send && (cmd_code_i == C_STORE);
  // Restore without any saved image is refused, not loaded with junk
  wire rst_ok = acc && is_send && (cmd_code_i == C_RESTORE) && nv_valid_r;
  wire cmd_ok = wr_ok || rd_ok || clr_ok || sto_ok || rst_ok;
  wire [15:0] wval = is_byte ? {8'h00, cmd_data_i[7:0]} : cmd_data_i;

  // Read mux; the descriptor is a constant, not a register
  logic [15:0] rd_mux;
  always_comb
  begin
    rd_mux = rd_fmt ? {8'h00, FMT_VAL} : 16'h0000;
    for (int i = 0; i < NREG; i++)
      if (hit[i])
        rd_mux = rd_mux | regs_r[i];
  end

  // Per-register decode, next value and storage
  genvar g;
  generate
    for (g = 0; g < NREG; g++)
    begin : g_reg
      wire [15:0] strap_v = (g == I_FREQ) ? freq_strap_i :
                            (g == I_PHASE) ? {12'h000, addr_strap_i[3:0]} :
                            scale(vout_strap_i, SCALE_TAB[g]);
      wire init_ld = (st_r == S_INIT) && STRAP_MASK[g];
      wire nv_ld = rvld_r && (ld_idx_r == IW'(g));
      assign hit[g] = cmd_code_i == CODE_TAB[g];
      assign reg_nxt[g] = init_ld ? strap_v :
                          (wr_ok && hit[g]) ? wval :
                          nv_ld ? nv.rdata : regs_r[g];
      always_ff @(posedge sys_clk_i)
      begin
        if (rst_i)
          regs_r[g] <= RST_TAB[g];
        else
          regs_r[g] <= reg_nxt[g];
      end
    end
  endgenerate

  // Store and restore walk every register once, one per cycle
  wire last_idx = idx_r == IW'(NREG - 1);
  wire walk_end = idx_r == IW'(NREG);
  always_comb
  begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    case (st_r)
      S_INIT:
        st_nxt = S_IDLE;
      S_IDLE:
      begin
        idx_nxt = '0;
        if (sto_ok)
          st_nxt = S_STORE;
        else if (rst_ok)
          st_nxt = S_RESTORE;
      end
      S_STORE:
      begin
        idx_nxt = idx_r + IW'(1);
        if (last_idx)
          st_nxt = S_IDLE;
      end
      S_RESTORE:
      begin
        idx_nxt = idx_r + IW'(1);
        if (walk_end)
          st_nxt = S_IDLE;
      end
      default:
        st_nxt = S_IDLE;
    endcase
  end

  assign nv.we = st_r == S_STORE;
  assign nv.re = (st_r == S_RESTORE) && !walk_end;
  assign nv.addr = idx_r;
  assign nv.wdata = regs_r[idx_r];

  // Sequencer registers
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      st_r <= S_INIT;
      idx_r <= '0;
      ld_idx_r <= '0;
      rvld_r <= 1'b0;
      nv_valid_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
      ld_idx_r <= idx_r;
      rvld_r <= nv.re;
      nv_valid_r <= nv_valid_r || (st_r == S_STORE && last_idx);
    end
  end

  // Target voltage: mode select, trim, then ceiling
  wire [1:0] mrg = regs_r[I_OP][5:4];
  wire [15:0] base = (mrg == MRG_HI) ? regs_r[I_MH] :
                     (mrg == MRG_LO) ? regs_r[I_ML] : regs_r[I_VSET];
  wire signed [17:0] sum = $signed({2'b00, base}) + 18'(signed'(regs_r[I_TRIM]));
  wire signed [17:0] cap = $signed({2'b00, regs_r[I_VMAX]});
  wire [15:0] tgt = (sum < 0) ? 16'h0000 :
                    (sum > cap) ? regs_r[I_VMAX] : sum[15:0];

  // On/off source selection
  wire [7:0] cfg = regs_r[I_ONOFF][7:0];
  wire cmd_on = !cfg[CFG_CMD] || regs_r[I_OP][OP_ON];
  wire pin_on = !cfg[CFG_PIN] || (en_pin_i == cfg[CFG_POL]);
  wire want_on = !cfg[CFG_USE] || (cmd_on && pin_on);
  assign en_nxt = want_on && !shut_r && (st_r != S_INIT);

  // Ramp: step per microsecond from the rate word
  wire tick = tick_r == 16'(TICK_CYCLES - 1);
  wire [15:0] step = rate_step(regs_r[I_RATE]);
  wire [15:0] dst = en_r ? tgt : 16'h0000;
  wire [15:0] gap = (vnow_r > dst) ? (vnow_r - dst) : (dst - vnow_r);
  wire [15:0] mv = (gap < step) ? gap : step;
  always_comb
  begin
    vnow_nxt = vnow_r;
    if (!en_r && cfg[CFG_IMM])
      vnow_nxt = 16'h0000; // Immediate off skips the ramp
    else if (tick && vnow_r < dst)
      vnow_nxt = vnow_r + mv;
    else if (tick && vnow_r > dst)
      vnow_nxt = vnow_r - mv;
  end
  wire settled = en_r && (vnow_r == tgt);

  // Voltage limits read zero until the strap load, so overvoltage checks wait for it
  wire mon_on = st_r != S_INIT;
  // Limit comparisons; undervoltage only once the ramp has landed
  assign cond[F_OVF] = mon_on && (vout_meas_i > regs_r[I_OVF]);
  assign cond[F_OVW] = mon_on && (vout_meas_i > regs_r[I_OVW]);
  assign cond[F_UVW] = settled && (vout_meas_i < regs_r[I_UVW]);
  assign cond[F_UVF] = settled && (vout_meas_i < regs_r[I_UVF]);
  assign cond[F_OC] = l11(iout_meas_i) > l11(regs_r[I_OC]);
  assign cond[F_UC] = l11(iout_meas_i) < l11(regs_r[I_UC]);
  assign cond[F_OT] = l11(temp_meas_i) > l11(regs_r[I_OT]);

  // Sticky flags: a condition present during the clear still sets
  assign flags_nxt = (clr_ok ? '0 : flags_r) | cond;
  wire ov_act = regs_r[I_OVR][RSP_HI] || regs_r[I_OVR][RSP_LO];
  wire uv_act = regs_r[I_UVR][RSP_HI] || regs_r[I_UVR][RSP_LO];
  assign shut_nxt = (clr_ok ? 1'b0 : shut_r) ||
                    (cond[F_OVF] && ov_act) ||
                    (cond[F_UVF] && uv_act);

  // Status, ramp and control state
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      flags_r <= '0;
      shut_r <= 1'b0;
      en_r <= 1'b0;
      vnow_r <= 16'h0000;
      tick_r <= 16'h0000;
    end
    else
    begin
      flags_r <= flags_nxt;
      shut_r <= shut_nxt;
      en_r <= en_nxt;
      vnow_r <= vnow_nxt;
      tick_r <= tick ? 16'h0000 : tick_r + 16'h0001;
    end
  end

  // Every request gets a one-cycle answer the cycle after it
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rsp_valid_r <= 1'b0;
      rsp_err_r <= 1'b0;
      rsp_data_r <= 16'h0000;
      busy_r <= 1'b1;
    end
    else
    begin
      rsp_valid_r <= cmd_valid_i;
      rsp_err_r <= cmd_valid_i && !cmd_ok;
      rsp_data_r <= rd_ok ? rd_mux : 16'h0000;
      busy_r <= st_nxt != S_IDLE;
    end
  end

  assign rsp_valid_o = rsp_valid_r;
  assign rsp_err_o = rsp_err_r;
  assign rsp_data_o = rsp_data_r;
  assign busy_o = busy_r;
  assign out_enable_o = en_r;
  assign vout_ref_o = vnow_r;
  assign freq_o = regs_r[I_FREQ];
  assign phase_o = regs_r[I_PHASE];
  assign droop_o = regs_r[I_DROOP];
  assign cs_gain_o = regs_r[I_GAIN];
  assign cs_offset_o = regs_r[I_CSOFF];
  assign flags_o = flags_r;

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence store_req;
    acc && is_send && cmd_code_i == C_STORE;
  endsequence
  sequence store_walk;
    nv.we [*8];
  endsequence

  a_fmt_read: assert property (rd_ok && rd_fmt |=> rsp_data_o == 16'h0013)
    else $error("format descriptor read wrong");
  a_store_walk: assert property (store_req |=> store_walk)
    else $error("store did not write the store");
  a_ov_flag: assert property (mon_on && vout_meas_i > regs_r[I_OVF] |=> flags_o[F_OVF])
    else $error("overvoltage fault not flagged");
  a_ov_shut: assert property (cond[F_OVF] && ov_act |-> ##[1:2] !out_enable_o)
    else $error("output stayed on after overvoltage fault");
  a_clear_flags: assert property (clr_ok && cond == '0 |=> flags_o == '0)
    else $error("fault clear left a flag set");
  a_oc_flag: assert property (cond[F_OC] |=> flags_o[F_OC])
    else $error("overcurrent not flagged");
  a_ot_flag: assert property (cond[F_OT] |=> flags_o[F_OT])
    else $error("over-temperature not flagged");
  a_ramp_rate: assert property (en_r && $stable(en_r) |=>
      ((vout_ref_o >= $past(vout_ref_o)) ? (vout_ref_o - $past(vout_ref_o))
       : ($past(vout_ref_o) - vout_ref_o)) <= $past(step))
    else $error("setpoint moved faster than the rate");
  a_word_write: assert property (wr_ok && hit[I_VSET] |=> regs_r[I_VSET] == $past(cmd_data_i))
    else $error("setpoint write lost");
endmodule

// [verif/pcr_host.sv]
// Host controller model that issues transfers on the command port
`timescale 1ns/10ps
module pcr_host
  import pcr_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rsp_valid_i,
  input wire logic rsp_err_i,
  input wire logic [15:0] rsp_data_i,
  output logic cmd_valid_o,
  output logic [2:0] cmd_kind_o,
  output logic [7:0] cmd_code_o,
  output logic [15:0] cmd_data_o
);
  // Idle port at time zero
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_kind_o = 3'h0;
    cmd_code_o = 8'h00;
    cmd_data_o = 16'h0000;
  end

  // One transfer: presented on a falling edge, held over one rising edge
  task automatic xfer(input logic [2:0] k, input logic [7:0] c, input logic [15:0] d,
                      output logic err, output logic [15:0] rd, output logic ok);
    int n;
    begin
      ok = 1'b0;
      @(negedge sys_clk_i);
      cmd_valid_o = 1'b1;
      cmd_kind_o = k;
      cmd_code_o = c;
      cmd_data_o = (k == K_SEND) ? 16'h0000 : (k == K_WBYTE) ? {8'h00, d[7:0]} : d;
      @(negedge sys_clk_i);
      // Released lines show inverted data, so a stale value never looks valid
      cmd_valid_o = 1'b0;
      cmd_code_o = ~c;
      cmd_data_o = ~d;
      for (n = 0; n < 3 && ok == 1'b0; n++)
      begin
        if (rsp_valid_i === 1'b1)
        begin
          ok = 1'b1;
          err = rsp_err_i;
          rd = rsp_data_i;
        end
        else
          @(negedge sys_clk_i);
      end
    end
  endtask
endmodule

// [verif/pcr_regmap_bench.sv]
// Self-checking bench for the command register map block
`timescale 1ns/10ps
module pcr_regmap_bench;
  import pcr_pkg::*;
  localparam int TK = 2;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic en_pin_i = 1'b0;
  logic [15:0] vout_meas_i = 16'h2000;
  logic [15:0] iout_meas_i = 16'h0000;
  logic [15:0] temp_meas_i = 16'h0000;
  logic cmd_valid, rsp_valid, rsp_err, busy, out_en, e, ok;
  logic [2:0] cmd_kind;
  logic [7:0] cmd_code;
  logic [15:0] cmd_data, rsp_data, vref, freq, phase, droop, gain, csoff, rd;
  logic [NFLAG-1:0] flags;
  int err_total = 0;
  int samples_checked = 0;
  int n;
  // Strap 1.0 V (2000h), so scaled defaults are floor(2000h*n/20)
  logic [7:0] tc [23] = '{8'h01, 8'h02, 8'h20, 8'h21, 8'h23, 8'h24, 8'h25, 8'h26,
    8'h27, 8'h28, 8'h33, 8'h37, 8'h38, 8'h39, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44,
    8'h45, 8'h46, 8'h4b, 8'h4f};
  logic [15:0] te [23] = '{16'h0000, 16'h0017, 16'h0013, 16'h2000, 16'h0000,
    16'h2333, 16'h2199, 16'h1e66, 16'hba00, 16'h0000, 16'h1234, 16'h000b,
    16'hb2ae, 16'h0000, 16'h24cc, 16'h0080, 16'h2333, 16'h1ccc, 16'h1b33,
    16'h0080, 16'he280, 16'he57f, 16'hebe8};

  always #20 sys_clk_i = ~sys_clk_i;

  pcr_regmap #(.TICK_CYCLES(TK)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .cmd_valid_i(cmd_valid), .cmd_kind_i(cmd_kind), .cmd_code_i(cmd_code),
    .cmd_data_i(cmd_data), .en_pin_i(en_pin_i), .vout_strap_i(16'h2000),
    .freq_strap_i(16'h1234), .addr_strap_i(7'h2b), .vout_meas_i(vout_meas_i),
    .iout_meas_i(iout_meas_i), .temp_meas_i(temp_meas_i), .rsp_valid_o(rsp_valid),
    .rsp_err_o(rsp_err), .rsp_data_o(rsp_data), .busy_o(busy), .out_enable_o(out_en),
    .vout_ref_o(vref), .freq_o(freq), .phase_o(phase), .droop_o(droop),
    .cs_gain_o(gain), .cs_offset_o(csoff), .flags_o(flags));

  pcr_host host (.sys_clk_i(sys_clk_i), .rsp_valid_i(rsp_valid), .rsp_err_i(rsp_err),
    .rsp_data_i(rsp_data), .cmd_valid_o(cmd_valid), .cmd_kind_o(cmd_kind),
    .cmd_code_o(cmd_code), .cmd_data_o(cmd_data));

  // Verdict and end of run
  task automatic results();
    if (err_total == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic hang();
    err_total++;
    results();
  endtask

  // One transfer; answer code always checked, data only on accepted reads
  task automatic acc(input logic [2:0] k, input logic [7:0] c, input logic [15:0] d,
                     input logic xe, input logic [15:0] xd);
    host.xfer(k, c, d, e, rd, ok);
    if (ok !== 1'b1)
      hang();
    chk({15'h0000, e}, {15'h0000, xe});
    if ((k == K_RBYTE || k == K_RWORD) && xe == 1'b0)
      chk(rd, xd);
  endtask

  // Counts cycles until the store or restore sequence lets go
  task automatic idle(output int cnt);
    for (cnt = 0; cnt < 60 && busy === 1'b1; cnt++)
      @(negedge sys_clk_i);
    if (cnt >= 60)
      hang();
  endtask

  // The bound doubles as a slowest allowed ramp
  task automatic wait_ref(input logic [15:0] x, input int lim);
    for (n = 0; n < lim && vref !== x; n++)
      @(negedge sys_clk_i);
    if (n >= lim)
      hang();
    chk(vref, x);
  endtask

  task automatic wait_flag(input int b);
    for (n = 0; n < 10 && flags[b] !== 1'b1; n++)
      @(negedge sys_clk_i);
    if (n >= 10)
      hang();
  endtask

  initial
  begin
    repeat (20) @(negedge sys_clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    // Reset and strap defaults of every register, byte codes read as bytes
    for (int i = 0; i < 23; i++)
      acc((tc[i] inside {8'h01, 8'h02, 8'h20, 8'h41, 8'h45}) ? K_RBYTE : K_RWORD,
          tc[i], 16'h0000, 1'b0, te[i]);
    chk(freq, 16'h1234);
    chk(phase, 16'h000b);
    // Configuration words reach their outputs
    acc(K_WWORD, 8'h28, 16'h0101, 1'b0, 16'h0000);
    acc(K_WWORD, 8'h33, 16'h0202, 1'b0, 16'h0000);
    acc(K_WWORD, 8'h37, 16'h0303, 1'b0, 16'h0000);
    acc(K_WWORD, 8'h38, 16'h0404, 1'b0, 16'h0000);
    acc(K_WWORD, 8'h39, 16'h0505, 1'b0, 16'h0000);
    chk(droop, 16'h0101);
    chk(freq, 16'h0202);
    chk(phase, 16'h0303);
    chk(gain, 16'h0404);
    chk(csoff, 16'h0505);
    // Refused accesses leave no trace
    acc(K_WBYTE, C_FMT, 16'h00ff, 1'b1, 16'h0000);
    acc(K_RBYTE, C_FMT, 16'h0000, 1'b0, 16'h0013);
    acc(K_WWORD, 8'h41, 16'h0000, 1'b1, 16'h0000);
    acc(K_WBYTE, 8'h21, 16'h0011, 1'b1, 16'h0000);
    acc(K_RBYTE, 8'h41, 16'h0000, 1'b0, 16'h0080);
    acc(K_RWORD, 8'h21, 16'h0000, 1'b0, 16'h2000);
    acc(K_RBYTE, C_CLEAR, 16'h0000, 1'b1, 16'h0000);
    acc(K_SEND, C_RESTORE, 16'h0000, 1'b1, 16'h0000);
    // Store, change, restore; requests during the copy are refused
    acc(K_WWORD, 8'h21, 16'h1f00, 1'b0, 16'h0000);
    acc(K_SEND, C_STORE, 16'h0000, 1'b0, 16'h0000);
    idle(n);
    chk(16'(n), 16'(NREG));
    acc(K_WWORD, 8'h21, 16'h1c00, 1'b0, 16'h0000);
    acc(K_WWORD, 8'h28, 16'h0000, 1'b0, 16'h0000);
    acc(K_SEND, C_RESTORE, 16'h0000, 1'b0, 16'h0000);
    acc(K_RWORD, 8'h21, 16'h0000, 1'b1, 16'h0000);
    idle(n);
    acc(K_RWORD, 8'h21, 16'h0000, 1'b0, 16'h1f00);
    acc(K_RWORD, 8'h28, 16'h0000, 1'b0, 16'h0101);
    // Ramp to trimmed setpoint, held under the ceiling
    en_pin_i = 1'b1;
    acc(K_WWORD, 8'h23, 16'h0100, 1'b0, 16'h0000);
    acc(K_WWORD, 8'h24, 16'h1f80, 1'b0, 16'h0000);
    wait_ref(16'h1f80, 1040 * TK);
    acc(K_WWORD, 8'h23, 16'h0000, 1'b0, 16'h0000);
    acc(K_WBYTE, 8'h01, 16'h0090, 1'b0, 16'h0000);
    acc(K_RBYTE, 8'h01, 16'h0000, 1'b0, 16'h0090);
    wait_ref(16'h1e66, 300);
    acc(K_WBYTE, 8'h01, 16'h00a0, 1'b0, 16'h0000);
    wait_ref(16'h1f80, 300);
    acc(K_WBYTE, 8'h01, 16'h0080, 1'b0, 16'h0000);
    wait_ref(16'h1f00, 300);
    // Overvoltage: limit itself is no fault, one step above shuts down
    vout_meas_i = 16'h24cc;
    repeat (4) @(negedge sys_clk_i);
    chk({9'h000, flags}, 16'h0002);
    vout_meas_i = 16'h24cd;
    wait_flag(F_OVF);
    chk({9'h000, flags}, 16'h0003);
    // Enable drops one cycle after the flag
    @(negedge sys_clk_i);
    chk({15'h0000, out_en}, 16'h0000);
    acc(K_SEND, C_CLEAR, 16'h0000, 1'b0, 16'h0000);
    chk({9'h000, flags}, 16'h0003);
    vout_meas_i = 16'h1f00;
    acc(K_SEND, C_CLEAR, 16'h0000, 1'b0, 16'h0000);
    chk({9'h000, flags}, 16'h0000);
    // Current and temperature just past their limits
    iout_meas_i = 16'he281;
    temp_meas_i = 16'hebe9;
    wait_flag(F_OT);
    chk({9'h000, flags}, 16'h0050);
    iout_meas_i = 16'he57e;
    wait_flag(F_UC);
    iout_meas_i = 16'h0000;
    temp_meas_i = 16'h0000;
    acc(K_SEND, C_CLEAR, 16'h0000, 1'b0, 16'h0000);
    chk({9'h000, flags}, 16'h0000);
    // Undervoltage once the ramp has landed: warning, then fault and shutdown
    wait_ref(16'h1f00, 1040 * TK);
    vout_meas_i = 16'h1c00;
    wait_flag(F_UVW);
    chk({9'h000, flags}, 16'h0004);
    vout_meas_i = 16'h1b00;
    wait_flag(F_UVF);
    @(negedge sys_clk_i);
    chk({15'h0000, out_en}, 16'h0000);
    chk({9'h000, flags}, 16'h000c);
    results();
  end
endmodule
